// *** src/dslp_delay_mem.sv ***
// dslp_delay_mem: small single port ring memory used as the line delay.
// assumes one write and one read of the same slot per bit, registered read.
module dslp_delay_mem #(
  parameter int unsigned DEPTH = 64,
  parameter int unsigned AW = 6
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [1:0] wdata,
  output logic [1:0] rdata_q
);

  initial begin
    if (DEPTH > (1 << AW) || DEPTH < 2) begin
      $error("dslp_delay_mem: depth does not fit address width");
    end
  end

  logic [1:0] mem [DEPTH];

  // ==========================================================
  // storage: read returns the old word, so a slot holds one full lap
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 2'h0;
    end else if (we) begin
      rdata_q <= mem[addr];
    end
  end

endmodule

// *** src/dslp_host_port.sv ***
// dslp_host_port: 8-bit asynchronous register port with interrupt.
// assumes strobes are already synchronous to clk and held several cycles.
module dslp_host_port (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic host_select_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out_q,
  output logic data_oe_q,
  output logic int_n_q,
  output logic [7:0] ctrl_q,
  input wire logic frame_event,
  input wire logic act_event
);

  logic wr_n_q;
  logic rd_n_q;
  logic [7:0] scratch_q;
  logic [7:0] status_q;
  logic [3:0] rd_addr_q;
  wire wr_rise = wr_n && !wr_n_q && !host_select_n;
  wire rd_rise = rd_n && !rd_n_q;
  wire rd_act = !rd_n && !host_select_n;
  wire clr_st = rd_rise && (rd_addr_q == dslp_pkg::ADDR_STATUS0);
  logic [7:0] rd_mux;

  // read selection
  always_comb begin
    unique case (addr)
      dslp_pkg::ADDR_STATUS0: rd_mux = status_q;
      dslp_pkg::ADDR_CTRL: rd_mux = ctrl_q;
      dslp_pkg::ADDR_SCRATCH: rd_mux = scratch_q;
      dslp_pkg::ADDR_ID: rd_mux = dslp_pkg::ID_VALUE;
      default: rd_mux = 8'h00;
    endcase
  end

  // ==========================================================
  // write on the strobe's rising edge while selected
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      ctrl_q <= dslp_pkg::CTRL_RST;
      scratch_q <= 8'h00;
    end else begin
      wr_n_q <= wr_n;
      rd_n_q <= rd_n;
      if (wr_rise && addr == dslp_pkg::ADDR_CTRL) ctrl_q <= data_in;
      if (wr_rise && addr == dslp_pkg::ADDR_SCRATCH) scratch_q <= data_in;
    end
  end

  // ==========================================================
  // bus drive: on while read low and selected, off once read rises or select drops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_oe_q <= 1'b0;
      data_out_q <= 8'h00;
      rd_addr_q <= 4'h0;
    end else begin
      data_oe_q <= rd_act;
      if (rd_act) begin
        data_out_q <= rd_mux;
        rd_addr_q <= addr;
      end
    end
  end

  // ==========================================================
  // sticky status; a new event beats the clear by read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= 8'h00;
      int_n_q <= 1'b1;
    end else begin
      status_q[7:2] <= 6'h00;
      status_q[dslp_pkg::ST_FRAME_BIT] <= frame_event ||
        (status_q[dslp_pkg::ST_FRAME_BIT] && !clr_st);
      status_q[dslp_pkg::ST_ACT_BIT] <= act_event ||
        (status_q[dslp_pkg::ST_ACT_BIT] && !clr_st);
      int_n_q <= !(frame_event || act_event || ((|status_q) && !clr_st));
    end
  end

endmodule

// *** src/dslp_pkg.sv ***
// dslp_pkg: constants shared by the dsl pump data port and host port.
// assumes one 250 MHz system clock (4 ns period) drives every register.
package dslp_pkg;

  // ==========================================================
  // clocking
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned CLK_NS = 4;
  // ratio of master clock to bit clock
  localparam int unsigned MCLK_PER_BIT = 16;
  localparam int unsigned BIT_KHZ_MIN = 272;
  localparam int unsigned BIT_KHZ_MAX = 1168;
  localparam int unsigned SYM_KHZ_MIN = 136;
  localparam int unsigned SYM_KHZ_MAX = 584;
  // master clock limits, in kHz (4.352 and 18.688 MHz)
  localparam int unsigned MCLK_KHZ_MIN = 4352;
  localparam int unsigned MCLK_KHZ_MAX = 18688;
  // default master clock half period in system cycles: 250e6/(2*8.704e6)
  localparam int unsigned MCLK_HALF_DEF = 14;
  // smallest legal half period: 250 MHz / (2 * 18.688 MHz), rounded up
  localparam int unsigned MCLK_HALF_MIN =
    (CLK_HZ / 1000 + 2 * MCLK_KHZ_MAX - 1) / (2 * MCLK_KHZ_MAX);
  // largest legal half period: 250 MHz / (2 * 4.352 MHz), rounded down
  localparam int unsigned MCLK_HALF_MAX = (CLK_HZ / 1000) / (2 * MCLK_KHZ_MIN);

  // ==========================================================
  // host port
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam logic [3:0] ADDR_STATUS0 = 4'h0;
  localparam logic [3:0] ADDR_CTRL = 4'h1;
  localparam logic [3:0] ADDR_SCRATCH = 4'h2;
  localparam logic [3:0] ADDR_ID = 4'h3;
  // identity value, arbitrary
  localparam logic [7:0] ID_VALUE = 8'h5a;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // ctrl field positions
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_MODE_W = 3;
  localparam int unsigned CTRL_LOOP_BIT = 3;
  // status0 field positions
  localparam int unsigned ST_FRAME_BIT = 0;
  localparam int unsigned ST_ACT_BIT = 1;
  // minimum reset low time
  localparam int unsigned RST_MIN_NS = 500;
  localparam int unsigned RST_MIN_CYC = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;

  // ==========================================================
  // framing
  localparam int unsigned FRAME_BITS = 48;
  // latency from tx frame to rx frame, in bits (typical)
  localparam int unsigned LAT_BITS_FRAMED = 60;
  localparam int unsigned LAT_BITS_INDEP = 58;

  typedef enum logic [2:0] {
    DSLP_M0, DSLP_M1, DSLP_M2, DSLP_M3, DSLP_M4, DSLP_M5, DSLP_M6, DSLP_M7
  } dslp_mode_t;

  function automatic logic dslp_framed(input logic [2:0] m);
    return (m == 3'h6) || (m == 3'h7);
  endfunction

  function automatic logic dslp_indep(input logic [2:0] m);
    return (m == 3'h4) || (m == 3'h5);
  endfunction

endpackage

// *** src/dslp_top.sv ***
// dslp_top: data port clocking, serial framing and host port of a dsl pump.
// assumes inputs synchronous to clk; the line itself is modelled as a
// loop delay from transmit to receive so the data path is exercised.
module dslp_top #(
  parameter int unsigned MCLK_HALF = dslp_pkg::MCLK_HALF_DEF,
  parameter int unsigned FRAME_BITS = dslp_pkg::FRAME_BITS
) (
  input wire logic clk,
  input wire logic rst_n,
  // serial data port
  input wire logic tx_data,
  input wire logic tx_frame_pulse,
  output logic rx_data_q,
  output logic rx_frame_pulse_q,
  output logic rx_data_status_q,
  output logic master_clock_out_q,
  output logic bit_clock_q,
  output logic tx_bit_clock_q,
  output logic rx_bit_clock_q,
  output logic symbol_clock_q,
  output logic tx_symbol_clock_q,
  output logic rx_symbol_clock_q,
  input wire logic activation_request,
  output logic activation_q,
  // host port
  input wire logic host_select_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out_q,
  output logic data_oe_q,
  output logic int_n_q
);

  initial begin
    if (MCLK_HALF < dslp_pkg::MCLK_HALF_MIN || MCLK_HALF > dslp_pkg::MCLK_HALF_MAX) begin
      $error("dslp_top: master clock half period out of range");
    end
    if (FRAME_BITS < 2 || FRAME_BITS > 255) begin
      $error("dslp_top: frame length unsupported");
    end
  end

  localparam int unsigned DLY_BITS = dslp_pkg::LAT_BITS_FRAMED;
  localparam int unsigned HALF_BIT = dslp_pkg::MCLK_PER_BIT / 2;

  // ==========================================================
  // master clock divider
  logic [7:0] mdiv_q;
  logic [3:0] mcnt_q;
  logic [1:0] act_sh_q;
  logic [7:0] act_cnt_q;
  logic act_last_q;
  logic [7:0] ctrl;
  logic frame_event;
  logic act_event;
  wire mclk_tick = (mdiv_q == 8'(MCLK_HALF - 1));
  wire m_rise = mclk_tick && !master_clock_out_q;
  // bit clock edges: bit high while master count is in its first half
  wire b_rise = m_rise && (mcnt_q == 4'h0);
  wire b_fall = m_rise && (mcnt_q == 4'(HALF_BIT));
  wire [2:0] mode = ctrl[dslp_pkg::CTRL_MODE_LSB +: dslp_pkg::CTRL_MODE_W];
  wire framed = dslp_pkg::dslp_framed(mode);
  wire indep = dslp_pkg::dslp_indep(mode);
  wire tx_take = framed ? b_rise : b_fall;
  wire rx_move = framed ? b_fall : b_rise;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mdiv_q <= 8'h00;
      master_clock_out_q <= 1'b0;
    end else begin
      mdiv_q <= mclk_tick ? 8'h00 : mdiv_q + 8'h01;
      if (mclk_tick) master_clock_out_q <= !master_clock_out_q;
    end
  end

  // ==========================================================
  // bit and symbol clocks, sixteen master periods per bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mcnt_q <= 4'h0;
      bit_clock_q <= 1'b0;
      tx_bit_clock_q <= 1'b0;
      rx_bit_clock_q <= 1'b0;
      symbol_clock_q <= 1'b0;
      tx_symbol_clock_q <= 1'b0;
      rx_symbol_clock_q <= 1'b0;
    end else begin
      if (m_rise) mcnt_q <= mcnt_q + 4'h1;
      if (b_rise || b_fall) begin
        bit_clock_q <= b_rise;
        tx_bit_clock_q <= b_rise;
        rx_bit_clock_q <= b_rise;
      end
      // symbol clock toggles on each bit rise: half the bit rate
      if (b_rise) begin
        symbol_clock_q <= !symbol_clock_q;
        tx_symbol_clock_q <= !tx_symbol_clock_q;
        rx_symbol_clock_q <= !rx_symbol_clock_q;
      end
    end
  end

  // ==========================================================
  // transmit capture and frame pulse sampling
  logic tx_bit_q;
  logic tx_fp_q;
  logic tx_take_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_bit_q <= 1'b0;
      tx_fp_q <= 1'b0;
      tx_take_q <= 1'b0;
    end else begin
      tx_take_q <= tx_take;
      if (tx_take) tx_bit_q <= tx_data;
      if (b_rise) tx_fp_q <= tx_frame_pulse;
      else if (tx_take) tx_fp_q <= 1'b0;
    end
  end

  // ==========================================================
  // loop delay line: bit and frame marker travel together
  logic [5:0] wptr_q;
  logic [1:0] dly_out;
  // the lap is one bit short: the receive word register adds the last bit
  wire [5:0] last_slot = indep ? 6'(dslp_pkg::LAT_BITS_INDEP - 2) : 6'(DLY_BITS - 2);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_q <= 6'h00;
    end else if (tx_take_q) begin
      wptr_q <= (wptr_q >= last_slot) ? 6'h00 : wptr_q + 6'h01;
    end
  end

  dslp_delay_mem #(
    .DEPTH(DLY_BITS),
    .AW(6)
  ) u_dly (
    .clk(clk),
    .rst_n(rst_n),
    .we(tx_take_q),
    .addr(wptr_q),
    .wdata({tx_fp_q, tx_bit_q}),
    .rdata_q(dly_out)
  );

  // ==========================================================
  // receive side: frame counting and status
  logic [7:0] rx_cnt_q;
  logic rx_locked_q;
  logic [1:0] rx_word_q;
  wire rx_fp_in = rx_word_q[1] && framed;
  wire rx_wrap = (rx_cnt_q == 8'(FRAME_BITS - 1));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_word_q <= 2'h0;
      rx_cnt_q <= 8'h00;
      rx_locked_q <= 1'b0;
    end else begin
      if (tx_take_q) rx_word_q <= dly_out;
      if (b_fall) begin
        if (rx_fp_in) begin
          rx_cnt_q <= 8'h00;
          rx_locked_q <= 1'b1;
        end else begin
          rx_cnt_q <= rx_wrap ? 8'h00 : rx_cnt_q + 8'h01;
        end
      end
    end
  end

  // outputs change only on the documented bit clock edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_data_q <= 1'b0;
      rx_frame_pulse_q <= 1'b0;
      rx_data_status_q <= 1'b0;
    end else begin
      if (rx_move) rx_data_q <= rx_word_q[0];
      if (b_fall) rx_frame_pulse_q <= rx_fp_in;
      // status: valid data once a frame marker has been received, or always outside framed modes
      if (b_fall) rx_data_status_q <= rx_locked_q || !framed;
    end
  end

  assign frame_event = b_fall && rx_fp_in;

  // ==========================================================
  // activation request: a level counts only after two bit highs
  wire act_lvl = act_sh_q[1];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      act_sh_q <= 2'h0;
      act_cnt_q <= 8'h00;
      act_last_q <= 1'b0;
      activation_q <= 1'b0;
    end else begin
      act_sh_q <= {act_sh_q[0], activation_request};
      if (act_lvl != act_last_q) begin
        act_last_q <= act_lvl;
        act_cnt_q <= 8'h00;
      end else if (b_fall && act_cnt_q != 8'h02) begin
        act_cnt_q <= act_cnt_q + 8'h01;
      end
      // filter glitch shorter than two bit clock high pulses
      if (act_cnt_q == 8'h02) activation_q <= act_last_q;
    end
  end

  assign act_event = (act_cnt_q == 8'h02) && (activation_q != act_last_q);

  // ==========================================================
  // host register port
  dslp_host_port u_host (
    .clk(clk),
    .rst_n(rst_n),
    .host_select_n(host_select_n),
    .rd_n(rd_n),
    .wr_n(wr_n),
    .addr(addr),
    .data_in(data_in),
    .data_out_q(data_out_q),
    .data_oe_q(data_oe_q),
    .int_n_q(int_n_q),
    .ctrl_q(ctrl),
    .frame_event(frame_event),
    .act_event(act_event)
  );

endmodule

// *** verification/dslp_framer_model.sv ***
// dslp_framer_model: framer at the serial port, sends markers and frames.
// assumes bit_clock is the device bit clock; drives on the clk fall.
module dslp_framer_model #(
  parameter int unsigned FBITS = 8
) (
  input wire logic clk,
  input wire logic bit_clock,
  input wire logic framed,
  input wire logic send,
  output logic tx_data,
  output logic tx_frame_pulse,
  output logic taken
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev_q = 1'b0;
  int unsigned nbit = 0;
  initial begin
    tx_data = 1'b0;
    tx_frame_pulse = 1'b0;
    taken = 1'b0;
  end
  // a one is shown only in the half bit ending at the capture edge,
  // so a device sampling on the wrong edge sees zero
  always @(negedge clk) begin
    taken <= 1'b0;
    prev_q <= bit_clock;
    if (bit_clock != prev_q) begin
      if (bit_clock == framed) begin
        taken <= tx_data;
        tx_data <= 1'b0;
        tx_frame_pulse <= 1'b0;
      end else begin
        tx_data <= send;
        tx_frame_pulse <= framed && nbit == 0;
        nbit <= (nbit + 1) % FBITS;
      end
    end
  end
endmodule

// *** verification/dslp_top_assertions.sv ***
// dslp_top_assertions: port timing checks for dslp_top.
// assumes it is bound to dslp_top; the mode is shadowed from host writes.
module dslp_top_assertions #(
  parameter int unsigned MCLK_HALF = 14,
  parameter int unsigned FRAME_BITS = 48
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rx_data_q,
  input wire logic rx_frame_pulse_q,
  input wire logic rx_data_status_q,
  input wire logic master_clock_out_q,
  input wire logic bit_clock_q,
  input wire logic tx_bit_clock_q,
  input wire logic rx_bit_clock_q,
  input wire logic symbol_clock_q,
  input wire logic host_select_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] data_in,
  input wire logic data_oe_q,
  input wire logic int_n_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // helper state
  logic wr_prev_q;
  logic [2:0] mode_q;
  logic [9:0] quiet_q;
  logic [9:0] mcnt_q;
  logic [9:0] bcnt_q;
  logic seen_q;
  wire ctrl_wr = wr_n && !wr_prev_q && !host_select_n && addr == dslp_pkg::ADDR_CTRL;
  wire framed = mode_q[2] && mode_q[1];
  wire settled = &quiet_q;
  // quiet masks the bits in flight across a mode switch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_prev_q <= 1'b1;
      mode_q <= 3'h0;
      quiet_q <= 10'h000;
      mcnt_q <= 10'h000;
      bcnt_q <= 10'h000;
      seen_q <= 1'b0;
    end else begin
      wr_prev_q <= wr_n;
      if (ctrl_wr) mode_q <= data_in[2:0];
      quiet_q <= ctrl_wr ? 10'h000 : quiet_q + {9'h000, !settled};
      mcnt_q <= $changed(master_clock_out_q) ? 10'h000 : mcnt_q + 10'h001;
      bcnt_q <= $changed(bit_clock_q) ? 10'h000 : bcnt_q + 10'h001;
      seen_q <= seen_q | $changed(bit_clock_q);
    end
  end

  // ==========================================================
  // clocks
  AST_BIT_SAME: assert property (@(posedge clk) disable iff (!rst_n)
    tx_bit_clock_q == bit_clock_q && rx_bit_clock_q == bit_clock_q)
    else $error("tx or rx bit clock differs from bit clock");
  AST_MCLK_HALF: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(master_clock_out_q) && seen_q |-> mcnt_q == 10'(MCLK_HALF - 1))
    else $error("master clock half period wrong");
  AST_BIT_HALF: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(bit_clock_q) && seen_q |-> bcnt_q == 10'(16 * MCLK_HALF - 1))
    else $error("bit clock half period wrong");
  AST_SYM_RISE: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(bit_clock_q) |-> ##[0:1] $changed(symbol_clock_q))
    else $error("symbol clock missed a bit clock rise");

  // ==========================================================
  // receive side launch edges
  AST_RX_FRAMED: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(rx_data_q) && framed && settled |-> $fell(bit_clock_q))
    else $error("rx data moved off a bit clock fall");
  AST_RX_OTHER: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(rx_data_q) && !framed && settled |-> $rose(bit_clock_q))
    else $error("rx data moved off a bit clock rise");
  AST_RFP_FALL: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(rx_frame_pulse_q) && settled |-> $fell(bit_clock_q))
    else $error("rx frame pulse moved off a bit clock fall");
  AST_RDST_FALL: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(rx_data_status_q) && settled |-> $fell(bit_clock_q))
    else $error("rx data status moved off a bit clock fall");

  // ==========================================================
  // host port; the reset check has no disable since reset is its cause
  AST_RST_IDLE: assert property (@(posedge clk)
    !rst_n |-> !data_oe_q && int_n_q)
    else $error("bus driven or interrupt set in reset");
  AST_INT_CLR: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(rd_n) && !host_select_n && addr == dslp_pkg::ADDR_STATUS0 && !framed
    |-> ##[1:2] int_n_q)
    else $error("status read left interrupt set");
  AST_RD_DRIVE: assert property (@(posedge clk) disable iff (!rst_n)
    !host_select_n && !rd_n |=> data_oe_q)
    else $error("read did not drive the bus");
  AST_RD_FLOAT: assert property (@(posedge clk) disable iff (!rst_n)
    rd_n || host_select_n |=> !data_oe_q)
    else $error("bus driven outside a read");
endmodule

// *** verification/dslp_top_tb_top.sv ***
// dslp_top_tb_top: self-checking bench for dslp_top with a framer model.
// assumes a short master clock half period and short frames for run time.
module dslp_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned MH = 7;
  localparam int unsigned FB = 8;
  localparam int unsigned P = 32 * MH;
  logic clk = 1'b0;
  logic rst_n = 1'b1;
  logic tx_data, tx_frame_pulse, rx_data_q, rx_frame_pulse_q, rx_data_status_q;
  logic master_clock_out_q, bit_clock_q, tx_bit_clock_q, rx_bit_clock_q;
  logic symbol_clock_q, tx_symbol_clock_q, rx_symbol_clock_q, activation_q;
  logic activation_request = 1'b0;
  logic host_select_n = 1'b1;
  logic rd_n = 1'b1;
  logic wr_n = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] data_in = 8'h00;
  logic [7:0] data_out_q;
  logic data_oe_q, int_n_q, framed, send, taken;
  logic [7:0] d;
  int miscompares = 0;
  int samples_checked = 0;
  wire [2:0] clks = {symbol_clock_q, bit_clock_q, master_clock_out_q};

  dslp_top #(.MCLK_HALF(MH), .FRAME_BITS(FB)) i_dut (.*);
  dslp_framer_model #(.FBITS(FB)) i_framer (.clk(clk), .bit_clock(bit_clock_q),
    .framed(framed), .send(send), .tx_data(tx_data),
    .tx_frame_pulse(tx_frame_pulse), .taken(taken));

  always #2 clk = ~clk;

  // ==========================================================
  // shared tasks
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %0h seen %0h", what, e, g);
    end
  endtask
  // strobes each stay two cycles, address held around them
  task automatic host_wr(input logic [3:0] a, input logic [7:0] v, input logic sel_n);
    addr = a;
    data_in = v;
    host_select_n = sel_n;
    repeat (2) @(negedge clk);
    wr_n = 1'b0;
    repeat (2) @(negedge clk);
    wr_n = 1'b1;
    repeat (2) @(negedge clk);
    host_select_n = 1'b1;
    @(negedge clk);
  endtask
  task automatic host_rd(input logic [3:0] a, output logic [7:0] v);
    addr = a;
    host_select_n = 1'b0;
    @(negedge clk);
    rd_n = 1'b0;
    repeat (2) @(negedge clk);
    v = data_out_q;
    chk("read drive", 1, data_oe_q);
    rd_n = 1'b1;
    repeat (2) @(negedge clk);
    host_select_n = 1'b1;
    repeat (2) @(negedge clk);
    chk("read float", 0, data_oe_q);
  endtask
  task automatic wait_hi(input logic [1:0] which, input int lim, output int n);
    n = 0;
    while (n < lim && !(which == 0 ? rx_data_q : which == 1 ? rx_frame_pulse_q
        : which == 2 ? activation_q : taken)) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic measure(input int which, output int n);
    n = 0;
    @(posedge clks[which]);
    @(posedge clks[which]);
    // step off the launching edge without counting it
    @(posedge clk);
    while (n < 4 * P && clks[which]) begin
      @(posedge clk);
      n++;
    end
    while (n < 4 * P && !clks[which]) begin
      @(posedge clk);
      n++;
    end
    // hand back on a falling edge so the next stimulus is off the sampling edge
    @(negedge clk);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_regs;
    host_wr(dslp_pkg::ADDR_SCRATCH, 8'ha5, 1'b0);
    host_wr(dslp_pkg::ADDR_SCRATCH, 8'h3c, 1'b1);
    host_rd(dslp_pkg::ADDR_SCRATCH, d);
    chk("scratch", 8'ha5, d);
    host_wr(dslp_pkg::ADDR_ID, 8'h00, 1'b0);
    host_rd(dslp_pkg::ADDR_ID, d);
    chk("id", dslp_pkg::ID_VALUE, d);
    host_rd(4'hf, d);
    chk("unmapped", 8'h00, d);
    for (int m = 7; m >= 0; m--) begin
      host_wr(dslp_pkg::ADDR_CTRL, 8'(m), 1'b0);
      host_rd(dslp_pkg::ADDR_CTRL, d);
      chk("ctrl mode", 8'(m), d);
    end
  endtask
  task automatic t_clocks;
    int n;
    measure(0, n);
    chk("master period", 2 * MH, n);
    measure(1, n);
    chk("bit period", P, n);
    chk("sixteen master periods per bit", 16 * 2 * MH, n);
    chk("bit rate in range", 1, 250000 / n >= 272 && 250000 / n <= 1168);
    measure(2, n);
    chk("symbol period", 2 * P, n);
    chk("symbol copies", {2{symbol_clock_q}}, {tx_symbol_clock_q, rx_symbol_clock_q});
  endtask
  task automatic t_activation(input logic lvl);
    int n;
    activation_request = lvl;
    wait_hi(2'd2, 4 * P, n);
    if (!lvl) repeat (4 * P) @(negedge clk);
    chk("activation", lvl, activation_q);
    chk("interrupt set", 0, int_n_q);
    host_rd(dslp_pkg::ADDR_STATUS0, d);
    chk("status act", 1, d[dslp_pkg::ST_ACT_BIT]);
    chk("interrupt cleared", 1, int_n_q);
  endtask
  task automatic t_latency(input logic [2:0] m, input int lat);
    int n;
    int w;
    framed = m[2] && m[1];
    host_wr(dslp_pkg::ADDR_CTRL, {5'h00, m}, 1'b0);
    repeat (4 * P) @(negedge clk);
    send = 1'b1;
    wait_hi(2'd3, 3 * P, n);
    send = 1'b0;
    wait_hi(2'd0, (lat + 2) * P, n);
    chk("latency", 1, n >= (lat - 1) * P && n <= (lat + 1) * P);
    for (w = 0; w < 2 * P && rx_data_q; w++) @(negedge clk);
    chk("rx bit width", P, w);
  endtask
  task automatic t_frame;
    int n;
    wait_hi(2'd1, (60 + 2 * FB) * P, n);
    for (n = 0; n < 2 * P && rx_frame_pulse_q; n++) @(negedge clk);
    chk("rx frame width", P, n);
    chk("rx data status", 1, rx_data_status_q);
    chk("frame interrupt", 0, int_n_q);
  endtask
  task automatic t_reset_mid;
    addr = dslp_pkg::ADDR_ID;
    host_select_n = 1'b0;
    rd_n = 1'b0;
    repeat (2) @(negedge clk);
    chk("drive before reset", 1, data_oe_q);
    rst_n = 1'b0;
    @(negedge clk);
    chk("float in reset", 0, data_oe_q);
    chk("int in reset", 1, int_n_q);
    rd_n = 1'b1;
    host_select_n = 1'b1;
    repeat (dslp_pkg::RST_MIN_CYC) @(negedge clk);
    rst_n = 1'b1;
    host_rd(dslp_pkg::ADDR_CTRL, d);
    chk("ctrl after reset", dslp_pkg::CTRL_RST, d);
  endtask

  initial begin
    framed = 1'b0;
    send = 1'b0;
    // a real falling edge of reset, before the first clock rise
    #1 rst_n = 1'b0;
    repeat (dslp_pkg::RST_MIN_CYC) @(negedge clk);
    chk("int in reset", 1, int_n_q);
    rst_n = 1'b1;
    @(negedge clk);
    t_regs();
    t_clocks();
    t_activation(1'b1);
    t_activation(1'b0);
    t_latency(3'h0, dslp_pkg::LAT_BITS_FRAMED);
    t_latency(3'h4, dslp_pkg::LAT_BITS_INDEP);
    t_latency(3'h6, dslp_pkg::LAT_BITS_FRAMED);
    t_frame();
    t_reset_mid();
    finish_test();
  end

  // watchdog sized from the longest latency scenarios plus margin
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    finish_test();
  end
endmodule

bind dslp_top dslp_top_assertions #(.MCLK_HALF(MCLK_HALF), .FRAME_BITS(FRAME_BITS)) i_chk (.*);
